// ==== common/pcg_regs.svh ====
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH
// Register offsets (byte addresses)
`define PCG_OFF_CTRL 8'h00
`define PCG_OFF_REFDV 8'h04
`define PCG_OFF_MULT 8'h08
`define PCG_OFF_SLOW 8'h0C
`define PCG_OFF_STAT 8'h10
// Control field positions
`define PCG_CTL_PWR 0
`define PCG_CTL_AUTO 1
`define PCG_CTL_ACQ 2
`define PCG_CTL_LIE 3
`define PCG_CTL_SYS 4
`define PCG_CTL_MOD 5
`define PCG_CTL_CAN 6
`define PCG_CTL_DBG 7
// Status field positions
`define PCG_ST_LOCK 0
`define PCG_ST_TRK 1
`define PCG_ST_FLAG 2
// Reset values
`define PCG_CTRL_RST 8'h02
`define PCG_REFDV_RST 3'h0
`define PCG_MULT_RST 6'h00
`define PCG_SLOW_RST 6'h00
// Slow divider step
`define PCG_SLOW_STEP 4
// Lock detector windows, in clock cycles of period error
`define PCG_TOL_LOCK 17'sh00004
`define PCG_TOL_UNL 17'sh00008
`define PCG_TOL_TRK 17'sh00008
`define PCG_TOL_UNT 17'sh00010
// Initial loop period estimate
`define PCG_PER_INIT 16'h0100
// Loop stabilization time after stop exit
`define PCG_CLK_MHZ 200
`define PCG_STAB_US 100
`define PCG_STAB_CYC (`PCG_STAB_US * `PCG_CLK_MHZ)
`endif

// ==== common/pcg_pkg.sv ====
package pcg_pkg;
	// Software control bits
	typedef struct packed {
		logic dbg_bus;
		logic can_sys;
		logic mod_tb;
		logic sys_loop;
		logic lie;
		logic wide_band_select;
		logic auto_bw;
		logic pwr;
	} pcg_ctrl_t;

	// Loop run state, one-hot
	typedef enum logic [3:0] {
		PCG_OFF = 4'h1,
		PCG_RUN = 4'h2,
		PCG_HALT = 4'h4,
		PCG_STAB = 4'h8
	} pcg_loop_t;

	// Clock enable bundle driven to consumers
	typedef struct packed {
		logic sys;
		logic bus;
		logic timebase;
		logic module_clk;
		logic can;
		logic debug;
		logic monitor;
	} pcg_clk_en_t;
endpackage

// ==== rtl/pcg_div.sv ====
`timescale 1ns/1ps
`default_nettype none
// Programmable enable divider: one pulse every div_i+1 input enables
module pcg_div #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Divider control
	input wire logic en_i,
	input wire logic [W-1:0] div_i,
	input wire logic clr_i,
	// Divided enable
	output logic pulse_o
);
	logic [W-1:0] cnt_q;

	// Counter restarts on clear so a new ratio takes effect cleanly
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_q <= '0;
			pulse_o <= 1'b0;
		end
		else if (clr_i)
		begin
			cnt_q <= '0;
			pulse_o <= 1'b0;
		end
		else
		begin
			pulse_o <= en_i && (cnt_q >= div_i);
			if (en_i)
			begin
				if (cnt_q >= div_i)
					cnt_q <= '0;
				else
					cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/pcg_clock_gen.sv ====
// Notes on behaviour
// R1: Slow divider divides crystal by 4 to 252 in steps of 4.
// R2: Reference divider divides crystal by any integer one to eight.
// R3: Loop multiplies reference by an integer factor one to sixty-four.
// R4: Module clock selects peripheral clock or timebase clock.
// R5: CAN clock comes from oscillator input or base system clock.
// R6: Debug logic clocked by debug clock or external bus clock.
// R7: Clock monitor runs from oscillator input regardless of selections.
// R8: Selected loop keeps running during processor wait mode.
// R9: Loop halts in stop; resumes same frequency after stabilization in automatic mode.
// R10: Lock detector compares feedback and reference frequency for mode and lock.
// R11: Filter acquires while select bit clear, tracks while it is set.
// R12: Automatic bandwidth control lets the detector switch filter modes itself.
// R13: Automatic mode: select bit read-only, set in tracking, cleared when untracked.
// R14: Lock bit read-only, set inside lock window, cleared outside unlock window.
// R15: Lock interrupt enabled raises a request on every lock bit toggle.
// R16: Manual mode keeps lock detection and interrupts, only switching disabled.
// R17: Manual mode: select bit writable and directly sets filter mode.
// R18: Software clears select bit before powering loop in manual mode.
// R19: Software waits acquisition time after power-on before selecting tracking.
// R20: Software selects loop output only when locked; unlock there is a fault.
// R21: Software may switch loop off before wait, then allow stabilization.
// R22: Loop output equals crystal divided by reference value times multiplier.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_regs.svh"
module pcg_clock_gen #(
	parameter int STAB_CYCLES = `PCG_STAB_CYC
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Oscillator pin and stop request
	input wire logic oscillator_input_clock_i,
	input wire logic stop_i,
	// Clock enables to consumers
	output pcg_pkg::pcg_clk_en_t clk_en_o,
	output logic [1:0] cpu_phase_clocks_o,
	output logic slow_calibration_clock_o,
	// Loop filter control and lock interrupt
	output logic loop_filter_track_o,
	output logic lock_irq_o
);
	import pcg_pkg::*;

	// ********************************************
	// Registers and signals
	// ********************************************
	pcg_ctrl_t ctrl_q;
	logic [2:0] refdv_q;
	logic [5:0] mult_q;
	logic [5:0] slow_q;
	logic wide_band_select_q;
	logic lock_q;
	logic lock_flag_q;
	logic lock_d1_q;
	logic lock_change;
	logic [2:0] osc_sync_q;
	logic xtal_en;
	logic final_reference_clock;
	logic feedback_divided_clock;
	logic slow_en;
	logic loop_tick_q;
	logic [16:0] acc_q;
	logic [15:0] per_q;
	logic [15:0] ref_cnt_q;
	logic [15:0] ref_per_q;
	logic [15:0] fb_cnt_q;
	logic signed [16:0] err;
	logic signed [16:0] err_abs;
	logic fb_seen_q;
	pcg_loop_t loop_q;
	logic [31:0] stab_q;
	logic running;
	logic cfg_wr;
	logic sys_src;
	logic bus_tog_q;
	logic bus_src;
	logic tb_src;
	logic [7:0] slow_div;

	// ********************************************
	// Oscillator pin input
	// ********************************************
	// Two flops before any logic, third stage gives the edge
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			osc_sync_q <= 3'h0;
		else
			osc_sync_q <= {osc_sync_q[1:0], oscillator_input_clock_i};
	end
	assign xtal_en = osc_sync_q[1] & ~osc_sync_q[2];

	// ********************************************
	// Register writes
	// ********************************************
	// A divider change restarts the loop measurement
	assign cfg_wr = wr_i && (addr_i == `PCG_OFF_REFDV || addr_i == `PCG_OFF_MULT);

	// Control and divider values
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ctrl_q <= `PCG_CTRL_RST;
			refdv_q <= `PCG_REFDV_RST;
			mult_q <= `PCG_MULT_RST;
			slow_q <= `PCG_SLOW_RST;
		end
		else if (wr_i)
		begin
			unique case (addr_i)
				`PCG_OFF_CTRL: ctrl_q <= wdata_i;
				`PCG_OFF_REFDV: refdv_q <= wdata_i[2:0];
				`PCG_OFF_MULT: mult_q <= wdata_i[5:0];
				`PCG_OFF_SLOW: slow_q <= wdata_i[5:0];
				default: ;
			endcase
		end
	end

	// ********************************************
	// Dividers
	// ********************************************
	// Reference: crystal divided by refdv+1 [R2]
	pcg_div #(.W(3)) u_ref_div (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.en_i(xtal_en),
		.div_i(refdv_q),
		.clr_i(cfg_wr),
		.pulse_o(final_reference_clock)
	);

	// Slow clock: field n gives divide by 4n, zero stops it [R1]
	assign slow_div = 8'((slow_q * `PCG_SLOW_STEP) - 1);
	pcg_div #(.W(8)) u_slow_div (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.en_i(xtal_en && slow_q != 6'h00),
		.div_i(slow_div),
		.clr_i(1'b0),
		.pulse_o(slow_en)
	);

	// Feedback: loop ticks divided by mult+1 [R10]
	pcg_div #(.W(6)) u_fb_div (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.en_i(loop_tick_q),
		.div_i(mult_q),
		.clr_i(cfg_wr),
		.pulse_o(feedback_divided_clock)
	);

	// ********************************************
	// Loop run state
	// ********************************************
	// Wait mode is not an input here: the loop runs on through it [R8]
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			loop_q <= PCG_OFF;
			stab_q <= '0;
		end
		else
		begin
			unique case (loop_q)
				PCG_OFF:
					if (ctrl_q.pwr)
						loop_q <= PCG_RUN;
				PCG_RUN:
					if (!ctrl_q.pwr)
						loop_q <= PCG_OFF;
					else if (stop_i)
						loop_q <= PCG_HALT; // [R9]
				PCG_HALT:
					if (!stop_i)
					begin
						loop_q <= PCG_STAB;
						stab_q <= '0;
					end
				PCG_STAB:
					if (stop_i)
						loop_q <= PCG_HALT;
					else if (stab_q >= 32'(STAB_CYCLES - 1))
						loop_q <= ctrl_q.pwr ? PCG_RUN : PCG_OFF; // [R9]
					else
						stab_q <= stab_q + 32'h1;
				default:
					loop_q <= PCG_OFF;
			endcase
		end
	end
	assign running = (loop_q == PCG_RUN);

	// ********************************************
	// Numeric oscillator
	// ********************************************
	// Each cycle adds mult+1; a tick every period/(mult+1) cycles [R3] [R22]
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			acc_q <= '0;
			loop_tick_q <= 1'b0;
		end
		else if (!running)
		begin
			acc_q <= '0;
			loop_tick_q <= 1'b0;
		end
		else if (acc_q >= {1'b0, per_q})
		begin
			acc_q <= acc_q - {1'b0, per_q} + 17'(mult_q) + 17'h1;
			loop_tick_q <= 1'b1;
		end
		else
		begin
			acc_q <= acc_q + 17'(mult_q) + 17'h1;
			loop_tick_q <= 1'b0;
		end
	end

	// ********************************************
	// Period measurement
	// ********************************************
	// Reference period in clock cycles
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ref_cnt_q <= '0;
			ref_per_q <= `PCG_PER_INIT;
		end
		else if (final_reference_clock)
		begin
			ref_cnt_q <= 16'h1;
			ref_per_q <= ref_cnt_q;
		end
		else if (ref_cnt_q != 16'hFFFF)
			ref_cnt_q <= ref_cnt_q + 16'h1;
	end

	// Feedback period counter; first edge after start only arms it
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			fb_cnt_q <= '0;
			fb_seen_q <= 1'b0;
		end
		else if (!running || cfg_wr)
		begin
			fb_cnt_q <= '0;
			fb_seen_q <= 1'b0;
		end
		else if (feedback_divided_clock)
		begin
			fb_cnt_q <= 16'h1;
			fb_seen_q <= 1'b1;
		end
		else if (fb_cnt_q != 16'hFFFF)
			fb_cnt_q <= fb_cnt_q + 16'h1;
	end

	// ********************************************
	// Lock detector and filter
	// ********************************************
	// Frequency error as a period difference [R10]
	assign err = $signed({1'b0, ref_per_q}) - $signed({1'b0, fb_cnt_q});
	assign err_abs = err[16] ? -err : err;

	// Period estimate: wide steps in acquisition, narrow in tracking [R11]
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			per_q <= `PCG_PER_INIT;
		else if (loop_q == PCG_OFF)
			per_q <= `PCG_PER_INIT;
		else if (loop_q == PCG_HALT && !ctrl_q.auto_bw)
			per_q <= `PCG_PER_INIT; // Manual restart reacquires [R9]
		else if (running && feedback_divided_clock && fb_seen_q)
		begin
			if (wide_band_select_q)
				per_q <= 16'($signed({1'b0, per_q}) + (err >>> 3));
			else
				per_q <= 16'($signed({1'b0, per_q}) + (err >>> 1));
		end
	end

	// Filter mode: detector in automatic, software in manual
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			wide_band_select_q <= 1'b0;
		else if (!ctrl_q.auto_bw)
		begin
			if (wr_i && addr_i == `PCG_OFF_CTRL)
				wide_band_select_q <= wdata_i[`PCG_CTL_ACQ]; // [R17]
		end
		else if (!running)
			wide_band_select_q <= 1'b0; // [R12]
		else if (feedback_divided_clock && fb_seen_q)
		begin
			if (err_abs <= `PCG_TOL_TRK)
				wide_band_select_q <= 1'b1; // [R13]
			else if (err_abs > `PCG_TOL_UNT)
				wide_band_select_q <= 1'b0; // [R13]
		end
	end

	// Lock bit works in both modes [R16]
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			lock_q <= 1'b0;
		else if (!running)
			lock_q <= 1'b0;
		else if (feedback_divided_clock && fb_seen_q)
		begin
			if (err_abs <= `PCG_TOL_LOCK)
				lock_q <= 1'b1; // [R14]
			else if (err_abs > `PCG_TOL_UNL)
				lock_q <= 1'b0; // [R14]
		end
	end

	// Lock change flag: a toggle beats a same-cycle write-one clear
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			lock_flag_q <= 1'b0;
		else if (lock_change)
			lock_flag_q <= 1'b1; // [R15] [R16]
		else if (wr_i && addr_i == `PCG_OFF_STAT && wdata_i[`PCG_ST_FLAG])
			lock_flag_q <= 1'b0;
	end

	// Previous lock level, for the toggle detector
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			lock_d1_q <= 1'b0;
		else
			lock_d1_q <= lock_q;
	end
	assign lock_change = lock_q ^ lock_d1_q;

	// Request follows flag gated by the enable [R15]
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			lock_irq_o <= 1'b0;
		else
			lock_irq_o <= lock_flag_q & ctrl_q.lie;
	end

	// ********************************************
	// Clock selection
	// ********************************************
	// Base clock from loop or crystal; software checks lock first [R20]
	assign sys_src = ctrl_q.sys_loop ? loop_tick_q : xtal_en;
	assign bus_src = sys_src & bus_tog_q;
	assign tb_src = (slow_q != 6'h00) ? slow_en : xtal_en;

	// Bus clock is half the base clock
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			bus_tog_q <= 1'b0;
			cpu_phase_clocks_o <= 2'h1;
		end
		else if (sys_src)
		begin
			bus_tog_q <= ~bus_tog_q;
			cpu_phase_clocks_o <= {cpu_phase_clocks_o[0], cpu_phase_clocks_o[1]};
		end
	end

	// All consumer enables leave from flops
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			clk_en_o <= '0;
			loop_filter_track_o <= 1'b0;
			slow_calibration_clock_o <= 1'b0;
		end
		else
		begin
			clk_en_o.sys <= sys_src;
			clk_en_o.bus <= bus_src;
			clk_en_o.timebase <= tb_src;
			clk_en_o.module_clk <= ctrl_q.mod_tb ? tb_src : bus_src; // [R4]
			clk_en_o.can <= ctrl_q.can_sys ? sys_src : xtal_en; // [R5]
			clk_en_o.debug <= ctrl_q.dbg_bus ? bus_src : sys_src; // [R6]
			clk_en_o.monitor <= xtal_en; // [R7]
			loop_filter_track_o <= wide_band_select_q; // [R11]
			if (slow_en)
				slow_calibration_clock_o <= ~slow_calibration_clock_o;
		end
	end

	// ********************************************
	// Register reads
	// ********************************************
	// Data stand one cycle after the read strobe, else zero
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_o <= 8'h00;
		else if (!rd_i)
			rdata_o <= 8'h00;
		else
		begin
			unique case (addr_i)
				`PCG_OFF_CTRL:
				begin
					rdata_o <= ctrl_q;
					rdata_o[`PCG_CTL_ACQ] <= wide_band_select_q; // [R13]
				end
				`PCG_OFF_REFDV: rdata_o <= {5'h00, refdv_q};
				`PCG_OFF_MULT: rdata_o <= {2'h0, mult_q};
				`PCG_OFF_SLOW: rdata_o <= {2'h0, slow_q};
				`PCG_OFF_STAT: rdata_o <= {5'h00, lock_flag_q, wide_band_select_q, lock_q};
				default: rdata_o <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== verification/pcg_osc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Crystal source model
// ************************************************************
// A crystal runs free, so the pin never idles; the start offset keeps its
// phase unrelated to the core clock
module pcg_osc_model #(
	parameter real HALF_NS = 20.0
) (
	// Oscillator pin
	output logic osc_o
);
	// Free running square wave
	initial
	begin
		osc_o = 1'b0;
		#3.3;
		forever
			#(HALF_NS) osc_o = ~osc_o;
	end
endmodule
`default_nettype wire

// ==== verification/pcg_clock_gen_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Pin level checker
// ************************************************************
module pcg_clock_gen_props #(
	parameter int STAB_CYCLES = 20000
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Oscillator and stop
	input wire logic oscillator_input_clock_i,
	input wire logic stop_i,
	// Consumer clocks and status
	input wire pcg_pkg::pcg_clk_en_t clk_en_o,
	input wire logic [1:0] cpu_phase_clocks_o,
	input wire logic slow_calibration_clock_o,
	input wire logic loop_filter_track_o,
	input wire logic lock_irq_o
);
	import pcg_pkg::*;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	logic [7:0] ctrl_q;

	// Shadow of the control byte, so gating can be judged from the pins alone
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			ctrl_q <= 8'h02;
		else if (wr_i && addr_i == 8'h00)
			ctrl_q <= wdata_i;
	end

	sequence s_read_unmapped;
		rd_i && !(addr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
	endsequence
	sequence s_osc_rise;
		$rose(oscillator_input_clock_i);
	endsequence

	property p_rd_idle;
		!rd_i |=> rdata_o == 8'h00;
	endproperty
	property p_unmapped;
		s_read_unmapped |=> rdata_o == 8'h00;
	endproperty
	property p_phase_onehot;
		$onehot(cpu_phase_clocks_o);
	endproperty
	// Either alignment of the registered enable against the phase flop is allowed
	property p_phase_on_sys;
		$changed(cpu_phase_clocks_o) |-> clk_en_o.sys || $past(clk_en_o.sys);
	endproperty
	property p_bus_half;
		clk_en_o.bus |=> !clk_en_o.bus;
	endproperty
	property p_monitor_osc;
		s_osc_rise |-> ##[2:6] clk_en_o.monitor;
	endproperty
	property p_irq_gated;
		!ctrl_q[3] && !$past(ctrl_q[3]) |-> !lock_irq_o;
	endproperty
	property p_debug_sel;
		$past(ctrl_q[7]) == ctrl_q[7] |-> clk_en_o.debug == (ctrl_q[7] ? clk_en_o.bus : clk_en_o.sys);
	endproperty

	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read slot");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");
	a_phase_onehot: assert property (p_phase_onehot) else $error("phase pair not one-hot");
	a_phase_on_sys: assert property (p_phase_on_sys) else $error("phase moved without base enable");
	a_bus_half: assert property (p_bus_half) else $error("bus enable on two cycles in a row");
	a_monitor_osc: assert property (p_monitor_osc) else $error("monitor missed a crystal tick");
	a_irq_gated: assert property (p_irq_gated) else $error("lock request while disabled");
	a_debug_sel: assert property (p_debug_sel) else $error("debug enable from wrong source");
endmodule

bind pcg_clock_gen pcg_clock_gen_props #(.STAB_CYCLES(STAB_CYCLES)) i_props (
	.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .oscillator_input_clock_i(oscillator_input_clock_i), .stop_i(stop_i),
	.clk_en_o(clk_en_o), .cpu_phase_clocks_o(cpu_phase_clocks_o),
	.slow_calibration_clock_o(slow_calibration_clock_o), .loop_filter_track_o(loop_filter_track_o),
	.lock_irq_o(lock_irq_o));
`default_nettype wire

// ==== verification/pcg_clock_gen_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcg_clock_gen_tb;
	import pcg_pkg::*;
	// ************************************************************
	// Setup: crystal of 8 core cycles, divide by 2, multiply by 4
	// ************************************************************
	localparam int WIN = 400;
	localparam int XT_N = WIN / 8;
	localparam int LOOP_N = XT_N * 4 / 2;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic stop_i = 1'b0;
	logic osc;
	logic [7:0] rdata_o;
	pcg_clk_en_t clk_en_o;
	logic [1:0] phase;
	logic slow_clk;
	logic track;
	logic irq;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;
	logic [7:0] d;
	logic [7:0] t_ctrl [8] = '{8'h0B, 8'h1B, 8'h1B, 8'h1B, 8'h5B, 8'h1B, 8'h9B, 8'h3B};
	int t_idx [8] = '{6, 6, 0, 2, 2, 1, 1, 3};
	int t_exp [8] = '{XT_N, LOOP_N, XT_N, XT_N, LOOP_N, LOOP_N, LOOP_N / 2, XT_N / 8};

	// Core clock, 200 MHz
	always #2.5 clock_i = ~clock_i;

	pcg_clock_gen #(.STAB_CYCLES(20)) i_dut (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.oscillator_input_clock_i(osc),
		.stop_i(stop_i),
		.clk_en_o(clk_en_o),
		.cpu_phase_clocks_o(phase),
		.slow_calibration_clock_o(slow_clk),
		.loop_filter_track_o(track),
		.lock_irq_o(irq)
	);
	pcg_osc_model #(.HALF_NS(20.0)) i_osc (.osc_o(osc));

	// ************************************************************
	// Access and compare tasks
	// ************************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Counts drift a little with crystal phase and loop settling
	task automatic near(input int got, input int exp);
		n_compared++;
		if (got < exp - 4 || got > exp + 4)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
		chk(d & m, e);
	endtask
	task automatic wait_lock();
		n = 0;
		d = 8'h00;
		while (d[0] !== 1'b1 && n < 15000)
		begin
			@(posedge clock_i);
			addr_i <= 8'h10;
			rd_i <= 1'b1;
			@(posedge clock_i);
			rd_i <= 1'b0;
			#1;
			d = rdata_o;
			n++;
		end
		chk(d & 8'h01, 8'h01);
	endtask
	task automatic cnt(input int idx, output int k);
		k = 0;
		repeat (WIN)
		begin
			@(posedge clock_i);
			#1;
			if (clk_en_o[idx] === 1'b1)
				k++;
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 100000)
		begin
			errors++;
			tally_and_finish();
		end
	end

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial
	begin
		repeat (12) @(posedge clock_i);
		rstn_i <= 1'b1;
		rc(8'h00, 8'hFF, 8'h02);
		rc(8'h14, 8'hFF, 8'h00);
		rc(8'h10, 8'hFF, 8'h00);
		wr(8'h04, 8'hFF);
		rc(8'h04, 8'hFF, 8'h07);
		wr(8'h08, 8'hFF);
		rc(8'h08, 8'hFF, 8'h3F);
		wr(8'h0C, 8'hFF);
		rc(8'h0C, 8'hFF, 8'h3F);
		wr(8'h04, 8'h01);
		wr(8'h08, 8'h03);
		wr(8'h0C, 8'h02);
		wr(8'h10, 8'h03);
		rc(8'h10, 8'h03, 8'h00);
		wr(8'h00, 8'h06);
		rc(8'h00, 8'hFF, 8'h02);
		$display("test registers done");
		wr(8'h00, 8'h0B);
		wait_lock();
		rc(8'h10, 8'h03, 8'h03);
		chk({7'h00, irq}, 8'h01);
		chk({7'h00, track}, 8'h01);
		wr(8'h10, 8'h04);
		repeat (3) @(posedge clock_i);
		chk({7'h00, irq}, 8'h00);
		$display("test automatic lock done");
		for (int i = 0; i < 8; i++)
		begin
			wr(8'h00, t_ctrl[i]);
			cnt(t_idx[i], n);
			near(n, t_exp[i]);
		end
		$display("test clock routing done");
		wr(8'h00, 8'h0B);
		stop_i <= 1'b1;
		repeat (10) @(posedge clock_i);
		rc(8'h10, 8'h01, 8'h00);
		@(posedge clock_i);
		stop_i <= 1'b0;
		wait_lock();
		wr(8'h00, 8'h1B);
		cnt(6, n);
		near(n, LOOP_N);
		$display("test stop done");
		wr(8'h00, 8'h00);
		wr(8'h00, 8'h09);
		wait_lock();
		chk({7'h00, track}, 8'h00);
		chk({7'h00, irq}, 8'h01);
		repeat (50) @(posedge clock_i);
		wr(8'h00, 8'h0D);
		rc(8'h00, 8'h04, 8'h04);
		chk({7'h00, track}, 8'h01);
		wr(8'h00, 8'h09);
		rc(8'h00, 8'h04, 8'h00);
		$display("test manual mode done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
